// ==== hw/comparator_map.vh ====
// register map, field positions and timing counts of the comparator control block
`ifndef COMPARATOR_MAP_VH
`define COMPARATOR_MAP_VH

// ****************************************************************
// register indices (byte address is four times the index)
// ****************************************************************
`define CMP1_CONTROL_IDX 14'h04C0
`define CMP1_REFERENCE_IDX 14'h04C2
`define CMP2_CONTROL_IDX 14'h04C4
`define CMP2_REFERENCE_IDX 14'h04C6
`define CMP3_CONTROL_IDX 14'h04C8
`define CMP3_REFERENCE_IDX 14'h04CA
`define CMP4_CONTROL_IDX 14'h04CC
`define CMP4_REFERENCE_IDX 14'h04CE

// ****************************************************************
// control register fields
// ****************************************************************
`define MODULE_ENABLE_BIT 15
`define STOP_IN_IDLE_BIT 13
`define INPUT_SELECT_HI 7
`define INPUT_SELECT_LO 6
`define EXT_REF_BIT 5
`define OUTPUT_STATE_BIT 3
`define POLARITY_BIT 1
`define RANGE_BIT 0
`define CONTROL_WRITE_MASK 16'hA0E3

// ****************************************************************
// reference register fields
// ****************************************************************
`define REF_CODE_HI 9
`define REF_CODE_LO 0
`define REFERENCE_WRITE_MASK 16'h03FF

// ****************************************************************
// reset values
// ****************************************************************
`define CONTROL_RESET 16'h0000
`define REFERENCE_RESET 16'h0000

// ****************************************************************
// timing
// ****************************************************************
`define CLK_PERIOD_NS 8
`define GLITCH_MIN_NS 66
`define GLITCH_CYCLES ((`GLITCH_MIN_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define FILT_CNT_W 4

`endif

// ==== hw/comparator_digital_control.v ====
// digital control and output conditioning for a bank of four analog comparators
//
// Overview of operation
// - filter out comparator pulses shorter than nine cycles
// - sleep or idle bypasses the filter for wake
// - stop-in-idle bit halts comparator during idle
// - any stop-in-idle bit halts whole group
// - one cycle pulse triggers ADC and interrupt
// - enable bit powers comparator and DAC
// - two bit field picks positive input pin
// - external reference bit routes external reference
// - status bit shows polarity adjusted output
// - polarity bit inverts comparator output
// - range bit picks DAC full scale
// - ten bit reference code drives DAC
// - reference register upper bits read zero
// - unused control bits read zero
// - per comparator adjacent registers, reset zero
// - selected pin digital buffer off when enabled
// - conditioned output feeds several consumers together
// - negative input fixed to DAC output
`include "comparator_map.vh"
`timescale 1ns/1ns
`default_nettype none

module comparator_digital_control #(
	parameter ADR_W = 16
) (
	// clock and reset
	input wire core_clk,
	input wire arst_n,
	// wishbone slave
	input wire wb_cyc_i,
	input wire wb_stb_i,
	input wire wb_we_i,
	input wire [ADR_W-1:0] wb_adr_i,
	input wire [3:0] wb_sel_i,
	input wire [31:0] wb_dat_i,
	output reg [31:0] wb_dat_o,
	output reg wb_ack_o,
	// power mode from the clock controller
	input wire sleep_mode,
	input wire idle_mode,
	// raw analog comparator outputs
	input wire [3:0] comp_raw,
	// analog control
	output reg [3:0] comp_power_on,
	output reg [3:0] dac_power_on,
	output reg [7:0] input_source_select,
	output reg [3:0] external_reference_select,
	output reg [3:0] range_high,
	output reg [39:0] reference_code,
	output reg [15:0] pad_digital_in_off,
	// conditioned outputs
	output reg [3:0] comp_level,
	output reg [3:0] adc_trigger,
	output reg [3:0] irq_request,
	output reg [3:0] wake_request
);

	// ****************************************************************
	// decode
	// ****************************************************************
	localparam integer FILT_CYCLES = `GLITCH_CYCLES;
	localparam [`FILT_CNT_W-1:0] FILT_LAST = FILT_CYCLES[`FILT_CNT_W-1:0] - 1'b1;

	// {hit, is_reference, comparator[1:0]}
	function [3:0] decode;
		input [13:0] idx;
		begin
			case (idx)
				`CMP1_CONTROL_IDX: decode = 4'b1000;
				`CMP1_REFERENCE_IDX: decode = 4'b1100;
				`CMP2_CONTROL_IDX: decode = 4'b1001;
				`CMP2_REFERENCE_IDX: decode = 4'b1101;
				`CMP3_CONTROL_IDX: decode = 4'b1010;
				`CMP3_REFERENCE_IDX: decode = 4'b1110;
				`CMP4_CONTROL_IDX: decode = 4'b1011;
				`CMP4_REFERENCE_IDX: decode = 4'b1111;
				default: decode = 4'b0000;
			endcase
		end
	endfunction

	// byte-lane merge of a 16-bit register
	function [15:0] merge;
		input [15:0] old;
		input [15:0] wr;
		input [1:0] sel;
		input [15:0] mask;
		reg [15:0] m;
		begin
			m = {{8{sel[1]}}, {8{sel[0]}}} & mask;
			merge = (old & ~m) | (wr & m);
		end
	endfunction

	// ****************************************************************
	// reset release
	// ****************************************************************
	reg [1:0] rst_sync_r;
	wire rst_n;

	always @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			rst_sync_r <= 2'b00;
		end else begin
			rst_sync_r <= {rst_sync_r[0], 1'b1};
		end
	end
	assign rst_n = rst_sync_r[1];

	// ****************************************************************
	// registers
	// ****************************************************************
	reg [15:0] control_r [0:3];
	reg [15:0] refcode_r [0:3];
	reg [3:0] state_r;
	wire [13:0] word_idx;
	wire [3:0] dec;
	wire bus_req;
	wire bus_wr;
	// one loop index per process, so no variable has two drivers
	integer i_reg;
	integer i_pwr;
	integer i_drv;
	integer i_syn;
	integer i_flt;
	integer i_pol;

	assign word_idx = wb_adr_i[15:2];
	assign dec = decode(word_idx);
	assign bus_req = wb_cyc_i & wb_stb_i;
	// write lands on the edge where the master sees ack
	assign bus_wr = bus_req & wb_we_i & wb_ack_o & dec[3];

	always @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			for (i_reg = 0; i_reg < 4; i_reg = i_reg + 1) begin
				control_r[i_reg] <= `CONTROL_RESET;
				refcode_r[i_reg] <= `REFERENCE_RESET;
			end
		end else if (bus_wr) begin
			if (dec[2]) begin
				refcode_r[dec[1:0]] <= merge(refcode_r[dec[1:0]], wb_dat_i[15:0],
					wb_sel_i[1:0], `REFERENCE_WRITE_MASK);
			end else begin
				control_r[dec[1:0]] <= merge(control_r[dec[1:0]], wb_dat_i[15:0],
					wb_sel_i[1:0], `CONTROL_WRITE_MASK);
			end
		end
	end

	// ****************************************************************
	// wishbone answer
	// ****************************************************************
	reg [15:0] rd_val;

	always @* begin
		rd_val = 16'h0000;
		if (dec[3]) begin
			if (dec[2]) begin
				rd_val = refcode_r[dec[1:0]] & `REFERENCE_WRITE_MASK;
			end else begin
				rd_val = control_r[dec[1:0]] & `CONTROL_WRITE_MASK;
				rd_val[`OUTPUT_STATE_BIT] = state_r[dec[1:0]] ^
					control_r[dec[1:0]][`POLARITY_BIT];
			end
		end
	end

	always @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			wb_ack_o <= 1'b0;
			wb_dat_o <= 32'h0000_0000;
		end else begin
			wb_ack_o <= bus_req & ~wb_ack_o;
			// unmapped reads answer zero, unmapped writes are dropped
			if (bus_req & ~wb_ack_o) begin
				wb_dat_o <= {16'h0000, rd_val};
			end
		end
	end

	// ****************************************************************
	// power and idle control
	// ****************************************************************
	reg [3:0] sidl_bits;
	reg [3:0] enabled;
	wire group_stop;
	wire [3:0] active;

	always @* begin
		sidl_bits = 4'h0;
		enabled = 4'h0;
		for (i_pwr = 0; i_pwr < 4; i_pwr = i_pwr + 1) begin
			sidl_bits[i_pwr] = control_r[i_pwr][`STOP_IN_IDLE_BIT];
			enabled[i_pwr] = control_r[i_pwr][`MODULE_ENABLE_BIT];
		end
	end

	// one shared stop keeps the clock gating simple for the group
	assign group_stop = idle_mode & (|sidl_bits);
	// registers are untouched by the stop, so leaving idle resumes at once
	assign active = enabled & {4{~group_stop}};

	// ****************************************************************
	// analog side drive
	// ****************************************************************
	always @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			comp_power_on <= 4'h0;
			dac_power_on <= 4'h0;
		end else begin
			comp_power_on <= active;
			dac_power_on <= active;
		end
	end

	always @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			input_source_select <= 8'h00;
			external_reference_select <= 4'h0;
			range_high <= 4'h0;
			reference_code <= 40'h00_0000_0000;
			pad_digital_in_off <= 16'h0000;
		end else begin
			for (i_drv = 0; i_drv < 4; i_drv = i_drv + 1) begin
				input_source_select[2*i_drv +: 2] <=
					control_r[i_drv][`INPUT_SELECT_HI:`INPUT_SELECT_LO];
				external_reference_select[i_drv] <= control_r[i_drv][`EXT_REF_BIT];
				range_high[i_drv] <= control_r[i_drv][`RANGE_BIT];
				reference_code[10*i_drv +: 10] <=
					refcode_r[i_drv][`REF_CODE_HI:`REF_CODE_LO];
				// analog levels would burn current in a live digital buffer
				pad_digital_in_off[4*i_drv +: 4] <= {4{enabled[i_drv]}} &
					(4'h1 << control_r[i_drv][`INPUT_SELECT_HI:`INPUT_SELECT_LO]);
			end
		end
	end

	// ****************************************************************
	// input synchroniser
	// ****************************************************************
	reg [3:0] sync1_r;
	reg [3:0] sync2_r;
	reg [3:0] sync3_r;
	reg [3:0] raw_r;

	always @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			sync1_r <= 4'h0;
			sync2_r <= 4'h0;
			sync3_r <= 4'h0;
			raw_r <= 4'h0;
		end else begin
			sync1_r <= comp_raw;
			sync2_r <= sync1_r;
			sync3_r <= sync2_r;
			for (i_syn = 0; i_syn < 4; i_syn = i_syn + 1) begin
				if (sync2_r[i_syn] == sync3_r[i_syn]) begin
					raw_r[i_syn] <= sync3_r[i_syn];
				end
			end
		end
	end

	// ****************************************************************
	// glitch filter
	// ****************************************************************
	reg [`FILT_CNT_W-1:0] cnt_r [0:3];
	wire low_power;

	assign low_power = sleep_mode | idle_mode;

	always @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			state_r <= 4'h0;
			for (i_flt = 0; i_flt < 4; i_flt = i_flt + 1) begin
				cnt_r[i_flt] <= {`FILT_CNT_W{1'b0}};
			end
		end else begin
			for (i_flt = 0; i_flt < 4; i_flt = i_flt + 1) begin
				if (!active[i_flt]) begin
					state_r[i_flt] <= 1'b0;
					cnt_r[i_flt] <= {`FILT_CNT_W{1'b0}};
				end else if (low_power) begin
					state_r[i_flt] <= raw_r[i_flt];
					cnt_r[i_flt] <= {`FILT_CNT_W{1'b0}};
				end else if (raw_r[i_flt] == state_r[i_flt]) begin
					cnt_r[i_flt] <= {`FILT_CNT_W{1'b0}};
				end else if (cnt_r[i_flt] == FILT_LAST) begin
					state_r[i_flt] <= raw_r[i_flt];
					cnt_r[i_flt] <= {`FILT_CNT_W{1'b0}};
				end else begin
					cnt_r[i_flt] <= cnt_r[i_flt] + 1'b1;
				end
			end
		end
	end

	// ****************************************************************
	// polarity and pulse generation
	// ****************************************************************
	reg [3:0] pol;
	reg [3:0] level_prev_r;
	wire [3:0] level;
	wire [3:0] rise;

	always @* begin
		pol = 4'h0;
		for (i_pol = 0; i_pol < 4; i_pol = i_pol + 1) begin
			pol[i_pol] = control_r[i_pol][`POLARITY_BIT];
		end
	end

	assign level = (state_r ^ pol) & active;
	assign rise = level & ~level_prev_r;

	always @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			level_prev_r <= 4'h0;
			comp_level <= 4'h0;
		end else begin
			level_prev_r <= level;
			comp_level <= level;
		end
	end

	// trigger and interrupt share one edge so consumers never disagree
	always @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			adc_trigger <= 4'h0;
		end else begin
			adc_trigger <= rise;
		end
	end

	always @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			irq_request <= 4'h0;
		end else begin
			irq_request <= rise;
		end
	end

	// wake still needs the clock: only the filter is skipped in low power
	always @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			wake_request <= 4'h0;
		end else begin
			wake_request <= rise & {4{low_power}};
		end
	end

endmodule // comparator_digital_control

`default_nettype wire

// ==== tb/comparator_monitor.sv ====
// assertion checker for the comparator control block
`timescale 1ns/1ns
`default_nettype none
module comparator_monitor (
	// clock and reset
	input wire logic core_clk,
	input wire logic arst_n,
	// register bus
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic [31:0] wb_dat_o,
	input wire logic wb_ack_o,
	// analog control and conditioned outputs
	input wire logic [3:0] comp_power_on,
	input wire logic [3:0] dac_power_on,
	input wire logic [15:0] pad_digital_in_off,
	input wire logic [3:0] comp_level,
	input wire logic [3:0] adc_trigger,
	input wire logic [3:0] irq_request,
	input wire logic [3:0] wake_request
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (!arst_n);
	// ****************
	// checks
	// ****************
	a_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
		else $error("ack held two cycles");
	a_ack_answer: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
		else $error("request not answered");
	a_read_upper: assert property (wb_ack_o |-> wb_dat_o[31:16] == 16'h0000)
		else $error("upper read bits set");
	a_trigger_rise: assert property (adc_trigger == (comp_level & ~$past(comp_level)))
		else $error("trigger not on level rise");
	a_irq_same: assert property (irq_request == adc_trigger)
		else $error("irq and trigger differ");
	a_wake_subset: assert property ((wake_request & ~irq_request) == 4'h0)
		else $error("wake without irq");
	a_dac_power: assert property (comp_power_on == dac_power_on)
		else $error("dac power differs");
	a_pad_one: assert property ($onehot0(pad_digital_in_off[3:0]))
		else $error("several pads off");
	// main scenarios
	c_trigger: cover property (adc_trigger[0]);
	c_wake: cover property (wake_request[0]);
	c_stop: cover property ($fell(comp_power_on[0]));
endmodule // comparator_monitor
bind comparator_digital_control comparator_monitor u_mon (.core_clk(core_clk), .arst_n(arst_n),
	.wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
	.comp_power_on(comp_power_on), .dac_power_on(dac_power_on), .pad_digital_in_off(pad_digital_in_off),
	.comp_level(comp_level), .adc_trigger(adc_trigger), .irq_request(irq_request),
	.wake_request(wake_request));
`default_nettype wire

// ==== tb/analog_comparator_model.sv ====
// behavioural model of the four analog comparators
`timescale 1ns/1ns
`default_nettype none
module analog_comparator_model (
	// analog decision wanted by the bench
	input wire logic [3:0] analog_in,
	// power from the block
	input wire logic [3:0] comp_power_on,
	// raw decisions
	output logic [3:0] comp_raw
);
	// unpowered comparator makes no decision, output sits low
	assign comp_raw = analog_in & comp_power_on;
endmodule // analog_comparator_model
`default_nettype wire

// ==== tb/tb.sv ====
// self-checking bench for the comparator control block
`timescale 1ns/1ns
`default_nettype none
module tb;
	logic core_clk, arst_n, cyc, stb, we, sleep, idle, ack;
	logic [15:0] adr, q, d, r;
	logic [31:0] dat, rdat;
	logic [3:0] ana, raw, pwr, dpw, xref, rng, lvl, trg, irq, wak;
	logic [7:0] isel;
	logic [39:0] code;
	logic [15:0] pad;
	int fails, checks, ntrig, nwake;
	comparator_digital_control DUT (.core_clk(core_clk), .arst_n(arst_n), .wb_cyc_i(cyc),
		.wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'h3), .wb_dat_i(dat),
		.wb_dat_o(rdat), .wb_ack_o(ack), .sleep_mode(sleep), .idle_mode(idle), .comp_raw(raw),
		.comp_power_on(pwr), .dac_power_on(dpw), .input_source_select(isel),
		.external_reference_select(xref), .range_high(rng), .reference_code(code),
		.pad_digital_in_off(pad), .comp_level(lvl), .adc_trigger(trg), .irq_request(irq),
		.wake_request(wak));
	analog_comparator_model u_ana (.analog_in(ana), .comp_power_on(pwr), .comp_raw(raw));
	task automatic conclude;
		if (fails == 0 && checks > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask
	task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
		checks++;
		if (g !== e) begin
			fails++;
			$display("mismatch %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic bus(input logic w, input logic [15:0] a, input logic [15:0] v);
		int n;
		n = 0;
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		dat <= {16'h0000, v};
		// hold the request until ack is sampled high at a rising edge
		do begin
			@(posedge core_clk);
			n++;
		end while (ack !== 1'b1 && n < 50);
		if (ack !== 1'b1) begin
			fails++;
			conclude();
		end
		q = rdat[15:0];
		cyc <= 1'b0;
		stb <= 1'b0;
		@(posedge core_clk);
	endtask
	function automatic logic [15:0] con_exp(input logic [15:0] v, input logic st);
		return (v & 16'hA0E3) | {12'h000, v[1] ^ st, 3'h0};
	endfunction
	task automatic pulse(input int len);
		ana[0] <= 1'b1;
		repeat (len) @(posedge core_clk);
		ana[0] <= 1'b0;
		repeat (20) @(posedge core_clk);
	endtask
	initial begin
		core_clk = 1'b0;
		forever #4 core_clk = ~core_clk;
	end
	always @(posedge core_clk) begin
		if (trg[0] === 1'b1) ntrig++;
		if (wak[0] === 1'b1) nwake++;
	end
	initial begin
		{arst_n, cyc, stb, we, sleep, idle, adr, dat, ana} = '0;
		{fails, checks, ntrig, nwake} = '0;
		void'($urandom(19));
		repeat (4) @(posedge core_clk);
		arst_n <= 1'b1;
		repeat (3) @(posedge core_clk);
		for (int i = 0; i < 9; i++) begin
			bus(1'b0, 16'h1300 + 16'(i * 8), 16'h0000);
			chk("reset", 16'h0000, q);
		end
		for (int k = 0; k < 4; k++) begin
			r = 16'($urandom);
			d = {k[0], r[14:8], k[1:0], r[5:0]};
			r = 16'($urandom);
			bus(1'b1, 16'h1300 + 16'(k * 16), d);
			bus(1'b1, 16'h1308 + 16'(k * 16), r);
			bus(1'b0, 16'h1300 + 16'(k * 16), 16'h0000);
			chk("control", con_exp(d, 1'b0), q);
			bus(1'b0, 16'h1308 + 16'(k * 16), 16'h0000);
			chk("reference", r & 16'h03FF, q);
			chk("analog", {d[15], d[15], d[7:6], d[5], d[0], r[9:0]},
				{pwr[k], dpw[k], isel[2*k+:2], xref[k], rng[k], code[10*k+:10]});
			chk("pad", d[15] ? 16'h0001 << d[7:6] : 16'h0000, {12'h000, pad[4*k+:4]});
			bus(1'b1, 16'h1300 + 16'(k * 16), 16'h0000);
		end
		bus(1'b1, 16'h1300, 16'h8000);
		repeat (20) @(posedge core_clk);
		ntrig = 0;
		pulse(8);
		chk("glitch", 16'h0000, {lvl, 12'(ntrig)});
		ana[0] <= 1'b1;
		repeat (40) @(posedge core_clk);
		chk("rise", 16'h1001, {lvl, 12'(ntrig)});
		bus(1'b0, 16'h1300, 16'h0000);
		chk("status", con_exp(16'h8000, 1'b1), q);
		bus(1'b1, 16'h1300, 16'h8002);
		ana[0] <= 1'b0;
		repeat (30) @(posedge core_clk);
		bus(1'b0, 16'h1300, 16'h0000);
		chk("polarity", con_exp(16'h8002, 1'b0), q);
		chk("inverted", 16'h1002, {lvl, 12'(ntrig)});
		bus(1'b1, 16'h1310, 16'hA000);
		idle <= 1'b1;
		repeat (4) @(posedge core_clk);
		chk("group stop", 16'h0000, {12'h000, pwr});
		idle <= 1'b0;
		repeat (4) @(posedge core_clk);
		chk("resume", 16'h0003, {12'h000, pwr});
		bus(1'b1, 16'h1310, 16'h8000);
		bus(1'b1, 16'h1300, 16'h8000);
		idle <= 1'b1;
		repeat (4) @(posedge core_clk);
		chk("idle run", 16'h0003, {12'h000, pwr});
		nwake = 0;
		pulse(2);
		chk("wake", 16'h0001, 16'(nwake));
		idle <= 1'b0;
		sleep <= 1'b1;
		nwake = 0;
		pulse(2);
		chk("sleep wake", 16'h0001, 16'(nwake));
		sleep <= 1'b0;
		conclude();
	end
endmodule // tb
`default_nettype wire
